// ### atobs_aux_observe.sv
// Aux pin observe registers: source select, two test DAC codes, converter snapshot,
// production-test bytes. Assumes a host interface decoder that issues single-cycle
// byte reads and writes, and core activity strobes on clk.
`include "atobs_regs.svh"

module atobs_aux_observe (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 rstn,
   // Host register access
   input  wire atobs_pkg::atobs_req_t  req,
   output logic [7:0]                rdata,
   output logic                      rvalid,
   // Reader core observation inputs
   input  wire atobs_pkg::atobs_core_t core,
   // Pin drive and DAC codes
   output atobs_pkg::atobs_pin_t     first_observe_pin,
   output atobs_pkg::atobs_pin_t     second_observe_pin,
   output logic [5:0]                dac_one_code,
   output logic [5:0]                dac_two_code
);
   import atobs_pkg::*;

   atobs_state_t st_r;
   atobs_state_t st_nxt;

   // ----------------------------------------
   // Pin source decode
   // ----------------------------------------
   // Shared by both pins; the DAC code means DAC one on pin one and DAC two on pin two,
   // which the analog mux resolves from the pin it sits on.
   function automatic atobs_pin_t pin_drive(input logic [3:0] sel, input atobs_core_t c);
      atobs_pin_t p;
      p.src    = sel;
      p.analog = 1'b0;
      p.level  = 1'b0;
      p.oe     = 1'b1;
      case (sel)
         `ATOBS_SEL_TRISTATE: p.oe = 1'b0;
         `ATOBS_SEL_DAC, `ATOBS_SEL_CORR, `ATOBS_SEL_MINIMUM_LEVEL_SIGNAL,
         `ATOBS_SEL_CONV_I, `ATOBS_SEL_CONV_Q: begin
            p.analog = 1'b1;
         end
         `ATOBS_SEL_HIGH:    p.level = 1'b1;
         `ATOBS_SEL_LOW:     p.level = 1'b0;
         // Core strobes already carry rate-dependent framing
         `ATOBS_SEL_TX_ACT:  p.level = c.tx_active;
         `ATOBS_SEL_RX_ACT:  p.level = c.rx_active;
         `ATOBS_SEL_SUBCARR: p.level = c.subcarrier;
         `ATOBS_SEL_TESTBUS: p.level = c.test_bus_bit;
         // Reserved codes keep the pin off so a stray write cannot drive it
         default:            p.oe = 1'b0;
      endcase
      return p;
   endfunction

   // Codes that put an analog test source on the pin
   function automatic logic is_analog_code(input logic [3:0] sel);
      return sel inside {`ATOBS_SEL_DAC, `ATOBS_SEL_CORR, `ATOBS_SEL_MINIMUM_LEVEL_SIGNAL,
                         `ATOBS_SEL_CONV_I, `ATOBS_SEL_CONV_Q};
   endfunction

   // Held-back codes; the pin must stay off for them
   function automatic logic is_reserved_code(input logic [3:0] sel);
      return sel inside {4'h3, 4'h7, 4'h8, 4'h9};
   endfunction

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      st_nxt        = st_r;
      st_nxt.rvalid = 1'b0;
      // Converter words come from the analog side: three flops, and a new word
      // counts only once the second and third stages agree, so a word caught
      // mid-change is never shown
      st_nxt.conv_s1 = {core.conv_i, core.conv_q};
      st_nxt.conv_s2 = st_r.conv_s1;
      st_nxt.conv_s3 = st_r.conv_s2;
      if (st_r.conv_s2 == st_r.conv_s3) begin
         st_nxt.snap = st_r.conv_s3;
      end
      if (req.wr) begin
         case (req.addr)
            `ATOBS_ADDR_SRC_SEL: st_nxt.src_sel = req.wdata;
            `ATOBS_ADDR_DAC_ONE: begin
               // Bit 7 belongs to production test and is kept; bit 6 is dropped
               st_nxt.dac_one = {req.wdata[`ATOBS_DAC_ONE_PT_BIT],
                                 req.wdata[`ATOBS_DAC_MSB:0]};
            end
            `ATOBS_ADDR_DAC_TWO: st_nxt.dac_two = req.wdata[5:0];
            `ATOBS_ADDR_RSVD_A:  st_nxt.rsvd_a  = req.wdata;
            `ATOBS_ADDR_RSVD_B:  st_nxt.rsvd_b  = req.wdata;
            `ATOBS_ADDR_RSVD_C:  st_nxt.rsvd_c  = req.wdata;
            `ATOBS_ADDR_RSVD_D:  st_nxt.rsvd_d  = req.wdata;
            default: ;
         endcase
      end
      if (req.rd) begin
         st_nxt.rvalid = 1'b1;
         case (req.addr)
            `ATOBS_ADDR_SRC_SEL: st_nxt.rdata = st_r.src_sel;
            `ATOBS_ADDR_DAC_ONE: begin
               // Bit 6 is future use and reads zero
               st_nxt.rdata = {st_r.dac_one[6], 1'b0, st_r.dac_one[5:0]};
            end
            `ATOBS_ADDR_DAC_TWO: st_nxt.rdata = {2'b00, st_r.dac_two};
            // A word that settles in this cycle is already shown
            `ATOBS_ADDR_SNAPSHOT: st_nxt.rdata = st_nxt.snap;
            `ATOBS_ADDR_RSVD_A:  st_nxt.rdata = st_r.rsvd_a;
            `ATOBS_ADDR_RSVD_B:  st_nxt.rdata = st_r.rsvd_b;
            `ATOBS_ADDR_RSVD_C:  st_nxt.rdata = st_r.rsvd_c;
            `ATOBS_ADDR_RSVD_D:  st_nxt.rdata = st_r.rsvd_d;
            default:             st_nxt.rdata = 8'h00;
         endcase
      end
      st_nxt.pin_one = pin_drive(st_nxt.src_sel[`ATOBS_FIRST_SRC_MSB:`ATOBS_FIRST_SRC_LSB],
                                 core);
      st_nxt.pin_two = pin_drive(st_nxt.src_sel[`ATOBS_SECOND_SRC_MSB:`ATOBS_SECOND_SRC_LSB],
                                 core);
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   // DAC codes have no documented reset value; they are cleared for determinism.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_r.src_sel <= `ATOBS_RST_SRC_SEL;
         st_r.dac_one <= {1'b0, `ATOBS_RST_DAC};
         st_r.dac_two <= `ATOBS_RST_DAC;
         st_r.rsvd_a  <= `ATOBS_RST_RSVD_A;
         st_r.rsvd_b  <= `ATOBS_RST_RSVD_B;
         st_r.rsvd_c  <= `ATOBS_RST_RSVD_C;
         st_r.rsvd_d  <= `ATOBS_RST_RSVD_D;
         st_r.rdata   <= 8'h00;
         st_r.rvalid  <= 1'b0;
         st_r.conv_s1 <= 8'h00;
         st_r.conv_s2 <= 8'h00;
         st_r.conv_s3 <= 8'h00;
         st_r.snap    <= 8'h00;
         st_r.pin_one <= '0;
         st_r.pin_two <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rdata              = st_r.rdata;
   assign rvalid             = st_r.rvalid;
   assign first_observe_pin  = st_r.pin_one;
   assign second_observe_pin = st_r.pin_two;
   assign dac_one_code       = st_r.dac_one[5:0];
   assign dac_two_code       = st_r.dac_two;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   // Pins lag the select and the core levels by one clock, hence |=> and $past
   property p_src_write;
      @(posedge clk) disable iff (!rstn)
      (req.wr && req.addr == `ATOBS_ADDR_SRC_SEL) ##1 (req.rd && !req.wr
         && req.addr == `ATOBS_ADDR_SRC_SEL) |=> (rdata == $past(req.wdata, 2));
   endproperty
   a_src_write: assert property (p_src_write) else $error("source select readback wrong");

   property p_analog;
      @(posedge clk) disable iff (!rstn)
      (first_observe_pin.src == `ATOBS_SEL_DAC || first_observe_pin.src == `ATOBS_SEL_CONV_Q)
         |-> (first_observe_pin.analog && first_observe_pin.oe);
   endproperty
   a_analog: assert property (p_analog) else $error("analog route not enabled");

   property p_tristate;
      @(posedge clk) disable iff (!rstn)
      (second_observe_pin.src == `ATOBS_SEL_TRISTATE || second_observe_pin.src == 4'h7)
         |-> !second_observe_pin.oe;
   endproperty
   a_tristate: assert property (p_tristate) else $error("pin driven when off");

   property p_fixed;
      @(posedge clk) disable iff (!rstn)
      (first_observe_pin.src == `ATOBS_SEL_HIGH) |-> first_observe_pin.level
         && first_observe_pin.oe && !first_observe_pin.analog;
   endproperty
   a_fixed: assert property (p_fixed) else $error("high code not high");

   property p_tx;
      @(posedge clk) disable iff (!rstn)
      (st_nxt.src_sel[7:4] == `ATOBS_SEL_TX_ACT)
         |=> first_observe_pin.level == $past(core.tx_active);
   endproperty
   a_tx: assert property (p_tx) else $error("transmit strobe not followed");

   property p_rx;
      @(posedge clk) disable iff (!rstn)
      (st_nxt.src_sel[3:0] == `ATOBS_SEL_RX_ACT)
         |=> second_observe_pin.level == $past(core.rx_active);
   endproperty
   a_rx: assert property (p_rx) else $error("receive strobe not followed");

   property p_bus;
      @(posedge clk) disable iff (!rstn)
      (st_nxt.src_sel[7:4] == `ATOBS_SEL_TESTBUS)
         |=> first_observe_pin.level == $past(core.test_bus_bit);
   endproperty
   a_bus: assert property (p_bus) else $error("test bus bit not followed");

   property p_snap;
      @(posedge clk) disable iff (!rstn)
      (req.rd && req.addr == `ATOBS_ADDR_SNAPSHOT && st_r.conv_s2 == st_r.conv_s3)
         |=> rvalid && rdata == $past(st_r.conv_s3);
   endproperty
   a_snap: assert property (p_snap) else $error("snapshot read wrong");

   property p_rfu;
      @(posedge clk) disable iff (!rstn)
      (req.rd && req.addr == `ATOBS_ADDR_DAC_TWO) |=> rdata[7:6] == 2'b00 && rdata[6] == 1'b0;
   endproperty
   a_rfu: assert property (p_rfu) else $error("future-use bits not zero");

   property p_src_pins;
      @(posedge clk) disable iff (!rstn)
      (req.wr && req.addr == `ATOBS_ADDR_SRC_SEL)
         |=> first_observe_pin.src == $past(req.wdata[7:4])
         && second_observe_pin.src == $past(req.wdata[3:0]);
   endproperty
   a_src_pins: assert property (p_src_pins) else $error("select not on pins");

   property p_src_stable;
      @(posedge clk) disable iff (!rstn)
      (req.wr && req.addr != `ATOBS_ADDR_SRC_SEL)
         |=> $stable(first_observe_pin.src) && $stable(second_observe_pin.src);
   endproperty
   a_src_stable: assert property (p_src_stable) else $error("select changed");

   property p_analog_two;
      @(posedge clk) disable iff (!rstn)
      is_analog_code(second_observe_pin.src)
         |-> second_observe_pin.analog && second_observe_pin.oe;
   endproperty
   a_analog_two: assert property (p_analog_two) else $error("analog route off");

   property p_reserved_one;
      @(posedge clk) disable iff (!rstn)
      is_reserved_code(first_observe_pin.src)
         |-> !first_observe_pin.oe && !first_observe_pin.analog;
   endproperty
   a_reserved_one: assert property (p_reserved_one) else $error("reserved code drives pin");

   property p_low_two;
      @(posedge clk) disable iff (!rstn)
      (second_observe_pin.src == `ATOBS_SEL_LOW) |-> !second_observe_pin.level
         && second_observe_pin.oe && !second_observe_pin.analog;
   endproperty
   a_low_two: assert property (p_low_two) else $error("low code not low");

   property p_high_two;
      @(posedge clk) disable iff (!rstn)
      (second_observe_pin.src == `ATOBS_SEL_HIGH) |-> second_observe_pin.level
         && second_observe_pin.oe && !second_observe_pin.analog;
   endproperty
   a_high_two: assert property (p_high_two) else $error("high code not high");

   property p_tx_two;
      @(posedge clk) disable iff (!rstn)
      (st_nxt.src_sel[3:0] == `ATOBS_SEL_TX_ACT)
         |=> second_observe_pin.level == $past(core.tx_active);
   endproperty
   a_tx_two: assert property (p_tx_two) else $error("transmit strobe not followed");

   property p_rx_one;
      @(posedge clk) disable iff (!rstn)
      (st_nxt.src_sel[7:4] == `ATOBS_SEL_RX_ACT)
         |=> first_observe_pin.level == $past(core.rx_active);
   endproperty
   a_rx_one: assert property (p_rx_one) else $error("receive strobe not followed");

   property p_strobe_gate;
      @(posedge clk) disable iff (!rstn)
      (second_observe_pin.src == `ATOBS_SEL_RX_ACT && second_observe_pin.level)
         |-> $past(core.rx_active);
   endproperty
   a_strobe_gate: assert property (p_strobe_gate) else $error("strobe outside frame");

   property p_sub;
      @(posedge clk) disable iff (!rstn)
      (st_nxt.src_sel[7:4] == `ATOBS_SEL_SUBCARR)
         |=> first_observe_pin.level == $past(core.subcarrier);
   endproperty
   a_sub: assert property (p_sub) else $error("subcarrier flag not followed");

   property p_bus_two;
      @(posedge clk) disable iff (!rstn)
      (st_nxt.src_sel[3:0] == `ATOBS_SEL_TESTBUS)
         |=> second_observe_pin.level == $past(core.test_bus_bit);
   endproperty
   a_bus_two: assert property (p_bus_two) else $error("test bus bit not followed");

   property p_dac_one;
      @(posedge clk) disable iff (!rstn)
      (req.wr && req.addr == `ATOBS_ADDR_DAC_ONE)
         |=> dac_one_code == $past(req.wdata[5:0]);
   endproperty
   a_dac_one: assert property (p_dac_one) else $error("dac one code not taken");

   property p_dac_two;
      @(posedge clk) disable iff (!rstn)
      (req.wr && req.addr == `ATOBS_ADDR_DAC_TWO)
         |=> dac_two_code == $past(req.wdata[5:0]);
   endproperty
   a_dac_two: assert property (p_dac_two) else $error("dac two code not taken");

   property p_rfu_one;
      @(posedge clk) disable iff (!rstn)
      (req.rd && req.addr == `ATOBS_ADDR_DAC_ONE) |=> rdata[6] == 1'b0;
   endproperty
   a_rfu_one: assert property (p_rfu_one) else $error("dac one bit 6 not zero");

   property p_snap_stable;
      @(posedge clk) disable iff (!rstn)
      (st_r.conv_s2 != st_r.conv_s3) |=> $stable(st_r.snap);
   endproperty
   a_snap_stable: assert property (p_snap_stable) else $error("unsettled word taken");

   property p_read_answer;
      @(posedge clk) disable iff (!rstn)
      1'b1 |=> rvalid == $past(req.rd);
   endproperty
   a_read_answer: assert property (p_read_answer) else $error("read answer mistimed");

endmodule

// ### atobs_pkg.sv
// Types of the aux observe group.
// Assumes atobs_regs.svh is on the include path.
package atobs_pkg;

   // Host register access, one byte at a time
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [5:0] addr;
      logic [7:0] wdata;
   } atobs_req_t;

   // Frame activity and analog test levels from the reader core
   typedef struct packed {
      logic       tx_active;
      logic       rx_active;
      logic       subcarrier;
      logic       correlator;
      logic       min_level;
      logic       test_bus_bit;
      logic [3:0] conv_i;
      logic [3:0] conv_q;
   } atobs_core_t;

   // Pin drive: select line for the analog mux, digital level, enable
   typedef struct packed {
      logic [3:0] src;
      logic       analog;
      logic       level;
      logic       oe;
   } atobs_pin_t;

   // Whole state of the block
   typedef struct packed {
      logic [7:0] src_sel;
      logic [6:0] dac_one;
      logic [5:0] dac_two;
      logic [7:0] rsvd_a;
      logic [7:0] rsvd_b;
      logic [7:0] rsvd_c;
      logic [7:0] rsvd_d;
      logic [7:0] rdata;
      logic       rvalid;
      logic [7:0] conv_s1;
      logic [7:0] conv_s2;
      logic [7:0] conv_s3;
      logic [7:0] snap;
      atobs_pin_t pin_one;
      atobs_pin_t pin_two;
   } atobs_state_t;

endpackage

// ### atobs_regs.svh
// Register offsets, field positions, reset values and selector codes of the aux observe group.
// Assumes it is included by the design file and the bench; definitions only.
`ifndef ATOBS_REGS_SVH
`define ATOBS_REGS_SVH

// ----------------------------------------
// Offsets
// ----------------------------------------
`define ATOBS_ADDR_SRC_SEL   6'h38
`define ATOBS_ADDR_DAC_ONE   6'h39
`define ATOBS_ADDR_DAC_TWO   6'h3A
`define ATOBS_ADDR_SNAPSHOT  6'h3B
`define ATOBS_ADDR_RSVD_A    6'h3C
`define ATOBS_ADDR_RSVD_B    6'h3D
`define ATOBS_ADDR_RSVD_C    6'h3E
`define ATOBS_ADDR_RSVD_D    6'h3F

// ----------------------------------------
// Fields
// ----------------------------------------
`define ATOBS_FIRST_SRC_MSB  7
`define ATOBS_FIRST_SRC_LSB  4
`define ATOBS_SECOND_SRC_MSB 3
`define ATOBS_SECOND_SRC_LSB 0
`define ATOBS_DAC_MSB        5
`define ATOBS_DAC_ONE_PT_BIT 7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ATOBS_RST_SRC_SEL    8'h00
`define ATOBS_RST_DAC        6'h00
`define ATOBS_RST_RSVD_A     8'hFF
`define ATOBS_RST_RSVD_B     8'h00
`define ATOBS_RST_RSVD_C     8'h03
`define ATOBS_RST_RSVD_D     8'h00

// ----------------------------------------
// Selector codes
// ----------------------------------------
`define ATOBS_SEL_TRISTATE   4'h0
`define ATOBS_SEL_DAC        4'h1
`define ATOBS_SEL_CORR       4'h2
`define ATOBS_SEL_MINIMUM_LEVEL_SIGNAL   4'h4
`define ATOBS_SEL_CONV_I     4'h5
`define ATOBS_SEL_CONV_Q     4'h6
`define ATOBS_SEL_HIGH       4'hA
`define ATOBS_SEL_LOW        4'hB
`define ATOBS_SEL_TX_ACT     4'hC
`define ATOBS_SEL_RX_ACT     4'hD
`define ATOBS_SEL_SUBCARR    4'hE
`define ATOBS_SEL_TESTBUS    4'hF

`endif

// ### atobs_tb.sv
// Self-checking bench for the aux observe register group.
// Assumes atobs_pkg and atobs_regs.svh are compiled and included ahead of it.
`include "atobs_regs.svh"

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import atobs_pkg::*;

   // ----------------------------------------
   // Signals and instance
   // ----------------------------------------
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   atobs_req_t  req;
   atobs_core_t core;
   logic [7:0]  rdata;
   logic        rvalid;
   atobs_pin_t  pin_a;
   atobs_pin_t  pin_b;
   logic [5:0]  dac_a;
   logic [5:0]  dac_b;
   int          n_errors = 0;
   int          total_checks = 0;
   int          cycles = 0;

   atobs_aux_observe i_dut (.clk(clk), .rstn(rstn), .req(req), .rdata(rdata),
      .rvalid(rvalid), .core(core), .first_observe_pin(pin_a),
      .second_observe_pin(pin_b), .dac_one_code(dac_a), .dac_two_code(dac_b));

   always #25 clk = ~clk;

   // Ceiling well above the few hundred cycles the scenarios need
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         $display("mismatch at %0t: run did not finish", $time);
         give_verdict();
      end
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic give_verdict();
      if (n_errors == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_pin(input atobs_pin_t pin, input logic [3:0] code);
      logic on;
      logic ana;
      logic lvl;
      on = !(code inside {4'h0, 4'h3, 4'h7, 4'h8, 4'h9});
      ana = code inside {4'h1, 4'h2, 4'h4, 4'h5, 4'h6};
      case (code)
         4'hA: lvl = 1'b1;
         4'hC: lvl = core.tx_active;
         4'hD: lvl = core.rx_active;
         4'hE: lvl = core.subcarrier;
         4'hF: lvl = core.test_bus_bit;
         default: lvl = 1'b0;
      endcase
      chk_byte({4'h0, pin.src}, {4'h0, code}, "pin source");
      chk_byte({7'h0, pin.oe}, {7'h0, on}, "pin enable");
      chk_byte({7'h0, pin.analog}, {7'h0, ana}, "pin analog route");
      if (code >= 4'hA) chk_byte({7'h0, pin.level}, {7'h0, lvl}, "pin level");
   endtask

   // Strobes rise at a falling edge and drop one cycle later
   task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
      @(negedge clk);
      req.wr = 1'b1;
      req.addr = a;
      req.wdata = d;
      @(negedge clk);
      req.wr = 1'b0;
   endtask

   task automatic rd_reg(input logic [5:0] a, input logic [7:0] exp);
      @(negedge clk);
      req.rd = 1'b1;
      req.addr = a;
      @(negedge clk);
      req.rd = 1'b0;
      // The answer stands for one cycle only
      chk_byte({7'h0, rvalid}, 8'h01, "read valid");
      chk_byte(rdata, exp, "read data");
      @(negedge clk);
      chk_byte({7'h0, rvalid}, 8'h00, "read valid width");
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset_values();
      chk_byte({6'h0, pin_a.oe, pin_b.oe}, 8'h00, "pins after reset");
      rd_reg(`ATOBS_ADDR_SRC_SEL, 8'h00);
      rd_reg(`ATOBS_ADDR_DAC_ONE, 8'h00);
      rd_reg(`ATOBS_ADDR_DAC_TWO, 8'h00);
      rd_reg(`ATOBS_ADDR_RSVD_A, 8'hFF);
      rd_reg(`ATOBS_ADDR_RSVD_B, 8'h00);
      rd_reg(`ATOBS_ADDR_RSVD_C, 8'h03);
      rd_reg(`ATOBS_ADDR_RSVD_D, 8'h00);
   endtask

   // Every code on both pins, each against two opposite core patterns
   task automatic t_selectors();
      logic [3:0] c;
      for (int i = 0; i < 16; i++) begin
         c = i[3:0];
         wr_reg(`ATOBS_ADDR_SRC_SEL, {c, 4'hF - c});
         for (int ph = 0; ph < 2; ph++) begin
            core[13:8] = (ph == 0) ? 6'h2A : 6'h15;
            repeat (2) @(negedge clk);
            chk_pin(pin_a, c);
            chk_pin(pin_b, 4'hF - c);
         end
         rd_reg(`ATOBS_ADDR_SRC_SEL, {c, 4'hF - c});
      end
   endtask

   task automatic t_dac();
      wr_reg(`ATOBS_ADDR_DAC_ONE, 8'hFF);
      rd_reg(`ATOBS_ADDR_DAC_ONE, 8'hBF);
      chk_byte({2'h0, dac_a}, 8'h3F, "dac one code");
      wr_reg(`ATOBS_ADDR_DAC_TWO, 8'hFF);
      rd_reg(`ATOBS_ADDR_DAC_TWO, 8'h3F);
      chk_byte({2'h0, dac_b}, 8'h3F, "dac two code");
      wr_reg(`ATOBS_ADDR_DAC_ONE, 8'h80);
      rd_reg(`ATOBS_ADDR_DAC_ONE, 8'h80);
      wr_reg(`ATOBS_ADDR_DAC_ONE, 8'h40);
      rd_reg(`ATOBS_ADDR_DAC_ONE, 8'h00);
      chk_byte({2'h0, dac_a}, 8'h00, "dac one code");
      wr_reg(`ATOBS_ADDR_DAC_TWO, 8'h95);
      chk_byte({2'h0, dac_b}, 8'h15, "dac two code");
   endtask

   // Snapshot ignores writes and tracks the converters
   task automatic t_snapshot();
      core.conv_i = 4'hA;
      core.conv_q = 4'h5;
      repeat (3) @(negedge clk);
      rd_reg(`ATOBS_ADDR_SNAPSHOT, 8'hA5);
      wr_reg(`ATOBS_ADDR_SNAPSHOT, 8'h00);
      core.conv_i = 4'h3;
      core.conv_q = 4'hC;
      repeat (3) @(negedge clk);
      rd_reg(`ATOBS_ADDR_SNAPSHOT, 8'h3C);
   endtask

   task automatic t_refused();
      rd_reg(6'h00, 8'h00);
      wr_reg(6'h10, 8'hFF);
      rd_reg(`ATOBS_ADDR_SRC_SEL, 8'hF0);
      wr_reg(`ATOBS_ADDR_RSVD_A, 8'h5A);
      rd_reg(`ATOBS_ADDR_RSVD_A, 8'h5A);
      chk_pin(pin_a, 4'hF);
      chk_pin(pin_b, 4'h0);
   endtask

   // Read beside a write sees the old value; a read right after sees the new one
   task automatic t_back_to_back();
      @(negedge clk);
      req.wr = 1'b1;
      req.rd = 1'b1;
      req.addr = `ATOBS_ADDR_SRC_SEL;
      req.wdata = 8'hC1;
      @(negedge clk);
      req.wr = 1'b0;
      chk_byte(rdata, 8'hF0, "read beside write");
      @(negedge clk);
      req.rd = 1'b0;
      chk_byte({7'h0, rvalid}, 8'h01, "back-to-back valid");
      chk_byte(rdata, 8'hC1, "read after write");
      @(negedge clk);
      chk_pin(pin_a, 4'hC);
      chk_pin(pin_b, 4'h1);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      req = '0;
      core = '0;
      repeat (6) @(negedge clk);
      rstn = 1'b1;
      t_reset_values();
      t_selectors();
      t_dac();
      t_snapshot();
      t_refused();
      t_back_to_back();
      // Second reset in mid-run must restore every value
      @(negedge clk);
      rstn = 1'b0;
      repeat (2) @(negedge clk);
      rstn = 1'b1;
      t_reset_values();
      give_verdict();
   end
endmodule
